// file: hdl/sfc_pkg.sv
// Constants for the servo fine control sequencer
package sfc_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned SETTLE_US = 1750;
  localparam int unsigned OFFCYL_US = 800;
  localparam int unsigned SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1000000));
  localparam int unsigned OFFCYL_CYC = (OFFCYL_US * (CLK_HZ / 1000000));
  localparam int unsigned CNT_W = 16;
  localparam logic [1:0] TAG_CTRL_SEL = 2'h3;
  localparam int unsigned BUS_OFS_PLUS = 2;
  localparam int unsigned BUS_OFS_MINUS = 3;
  localparam int unsigned BUS_HOME = 6;
  localparam logic [31:0] ADDR_CTRL = 32'h00000000;
  localparam logic [31:0] ADDR_STAT = 32'h00000004;
  localparam logic [31:0] ADDR_IRQ_ST = 32'h00000008;
  localparam logic [31:0] ADDR_IRQ_CLR = 32'h0000000C;
  localparam logic [31:0] ADDR_IRQ_EN = 32'h00000010;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_FINE = 0;
  localparam int unsigned IRQ_ONCYL = 1;
  localparam int unsigned IRQ_ERR = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SQ_IDLE, SQ_COARSE, SQ_FINE, SQ_DONE} sfc_state_e;
endpackage

// file: hdl/sfc_sync_if.sv
// Synchronised comparator levels between sync stage and sequencer
`timescale 1ns/1ps
interface sfc_sync_if;
  logic fine_lvl;
  logic oncyl_sense;
  logic off_track;
  modport src (output fine_lvl, output oncyl_sense, output off_track);
  modport dst (input fine_lvl, input oncyl_sense, input off_track);
endinterface

// file: hdl/sfc_sync.sv
// Two-flop synchroniser for the analog comparator outputs
`timescale 1ns/1ps
module sfc_sync
  import sfc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] raw_i,
  sfc_sync_if.src sy
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else begin
      meta_q <= raw_i;
      sync_q <= meta_q;
    end
  end
  assign sy.fine_lvl = sync_q[0];
  assign sy.oncyl_sense = sync_q[1];
  assign sy.off_track = sync_q[2];
endmodule // sfc_sync

// file: hdl/sfc_top.sv
// Servo fine control sequencer with AXI4-Lite registers
// Behaviour
// - Fine latch selects fine path, else coarse
// - Seek start clears fine latch
// - Last-cylinder flag when one cylinder remains
// - Fine enable from half-cylinder level detect
// - Fine latch sets on enable and last-cylinder
// - Polarity flop set for odd destination
// - On-cylinder detection only after fine latch
// - Sense starts settle delay, then on-cylinder
// - Seek end and on-cylinder out when on-cylinder
// - Sustained off-track clears on-cylinder
// - That loss raises seek error
// - Fine path stays selected while on-cylinder
// - Control tag with bit 2 or 3 is offset
// - Plus biases toward spindle, minus away
// - Seek error blocks seeks until home command
// - Seek end at success or error
`timescale 1ns/1ps
module sfc_top
  import sfc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SEEK_START_I,
  input wire logic DEST_ODD_I,
  input wire logic [8:0] DIFF_COUNT_I,
  input wire logic FINE_LVL_I,
  input wire logic ONCYL_SENSE_I,
  input wire logic OFF_TRACK_I,
  input wire logic TAG_STROBE_I,
  input wire logic [1:0] TAG_I,
  input wire logic [9:0] BUS_I,
  output logic FINE_GATE_O,
  output logic COARSE_GATE_O,
  output logic LAST_CYL_O,
  output logic FEEDBACK_POLARITY_O,
  output logic ON_CYL_O,
  output logic SEEK_END_O,
  output logic SEEK_ERROR_O,
  output logic OFFSET_PLUS_O,
  output logic OFFSET_MINUS_O,
  output logic RETURN_HOME_O,
  output logic IRQ_O,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  sfc_sync_if sy ();
  sfc_sync u_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .raw_i({OFF_TRACK_I, ONCYL_SENSE_I, FINE_LVL_I}),
    .sy(sy)
  );

  sfc_state_e state_q;
  logic fine_q;
  logic fine_en_q;
  logic last_cyl_q;
  logic polarity_q;
  logic oncyl_q;
  logic err_q;
  logic seek_end_q;
  logic ofs_plus_q;
  logic ofs_minus_q;
  logic home_q;
  logic [CNT_W-1:0] settle_cnt_q;
  logic [CNT_W-1:0] off_cnt_q;
  logic settling_q;
  logic sw_seek_q;
  logic sw_home_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic irq_q;

  logic seek_go;
  logic ctrl_tag;
  logic home_cmd;
  logic settle_done;
  logic off_done;
  logic fine_set;
  logic [IRQ_W-1:0] ev;

  assign ctrl_tag = TAG_STROBE_I && (TAG_I == TAG_CTRL_SEL);
  assign home_cmd = (ctrl_tag && BUS_I[BUS_HOME]) || sw_home_q;
  assign seek_go = (SEEK_START_I || sw_seek_q) && !err_q;
  assign fine_set = fine_en_q && last_cyl_q && !fine_q;
  assign settle_done = settling_q && (settle_cnt_q == CNT_W'(SETTLE_CYC - 1));
  assign off_done = oncyl_q && (off_cnt_q == CNT_W'(OFFCYL_CYC - 1));

  // Sequence state
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_q <= SQ_IDLE;
    end else if (seek_go) begin
      state_q <= SQ_COARSE;
    end else begin
      case (state_q)
        SQ_IDLE: state_q <= SQ_IDLE;
        SQ_COARSE: if (fine_set) state_q <= SQ_FINE;
        SQ_FINE: if (settle_done) state_q <= SQ_DONE;
        SQ_DONE: if (off_done) state_q <= SQ_IDLE;
        default: state_q <= SQ_IDLE;
      endcase
    end
  end

  // Last-cylinder flag, fine enable and fine latch
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      last_cyl_q <= 1'b0;
      fine_en_q <= 1'b0;
      fine_q <= 1'b0;
    end else begin
      last_cyl_q <= (DIFF_COUNT_I == 9'h001);
      fine_en_q <= sy.fine_lvl && (state_q == SQ_COARSE);
      if (seek_go) begin
        fine_q <= 1'b0;
      end else if (fine_set && state_q == SQ_COARSE) begin
        fine_q <= 1'b1;
      end
    end
  end

  // Feedback polarity flop
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      polarity_q <= 1'b0;
    end else if (seek_go) begin
      polarity_q <= DEST_ODD_I;
    end
  end

  // Settle delay and on-cylinder flop
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      settling_q <= 1'b0;
      settle_cnt_q <= CNT_W'(0);
      oncyl_q <= 1'b0;
    end else if (seek_go || !fine_q) begin
      settling_q <= 1'b0;
      settle_cnt_q <= CNT_W'(0);
      oncyl_q <= 1'b0;
    end else begin
      if (!oncyl_q && !settling_q && sy.oncyl_sense) begin
        settling_q <= 1'b1;
        settle_cnt_q <= CNT_W'(0);
      end else if (settle_done) begin
        settling_q <= 1'b0;
        oncyl_q <= 1'b1;
      end else if (settling_q) begin
        settle_cnt_q <= settle_cnt_q + CNT_W'(1);
      end
      if (off_done) begin
        oncyl_q <= 1'b0;
      end
    end
  end

  // Off-cylinder delay
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      off_cnt_q <= CNT_W'(0);
    end else if (!oncyl_q || !sy.off_track || off_done) begin
      off_cnt_q <= CNT_W'(0);
    end else begin
      off_cnt_q <= off_cnt_q + CNT_W'(1);
    end
  end

  // Seek error and seek end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      err_q <= 1'b0;
      seek_end_q <= 1'b0;
    end else begin
      if (off_done) begin
        err_q <= 1'b1;
      end else if (home_cmd) begin
        err_q <= 1'b0;
      end
      if (seek_go) begin
        seek_end_q <= 1'b0;
      end else begin
        seek_end_q <= settle_done || oncyl_q || err_q || off_done;
      end
    end
  end

  // Offset and home commands
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ofs_plus_q <= 1'b0;
      ofs_minus_q <= 1'b0;
      home_q <= 1'b0;
    end else begin
      if (ctrl_tag) begin
        ofs_plus_q <= BUS_I[BUS_OFS_PLUS];
        ofs_minus_q <= BUS_I[BUS_OFS_MINUS] && !BUS_I[BUS_OFS_PLUS];
      end
      home_q <= home_cmd;
    end
  end

  // Interrupt status, enable, output
  assign ev = {off_done, settle_done, fine_set && state_q == SQ_COARSE};
  logic aw_ok;
  logic aw_hs;
  assign aw_hs = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
  assign aw_ok = aw_hs && S_AXI_WSTRB[0];
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      irq_st_q <= 3'h0;
      irq_en_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      if (aw_ok && S_AXI_AWADDR == ADDR_IRQ_EN) begin
        irq_en_q <= S_AXI_WDATA[IRQ_W-1:0];
      end
      if (aw_ok && S_AXI_AWADDR == ADDR_IRQ_CLR) begin
        irq_st_q <= (irq_st_q & ~S_AXI_WDATA[IRQ_W-1:0]) | ev;
      end else begin
        irq_st_q <= irq_st_q | ev;
      end
      irq_q <= |(irq_st_q & irq_en_q);
    end
  end

  // AXI4-Lite write side
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
      sw_seek_q <= 1'b0;
      sw_home_q <= 1'b0;
    end else begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      sw_seek_q <= 1'b0;
      sw_home_q <= 1'b0;
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end else if (aw_hs && !S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= RESP_OKAY;
        if (S_AXI_AWADDR == ADDR_CTRL && S_AXI_WSTRB[0]) begin
          sw_seek_q <= S_AXI_WDATA[0];
          sw_home_q <= S_AXI_WDATA[1];
        end else if (S_AXI_AWADDR != ADDR_IRQ_CLR && S_AXI_AWADDR != ADDR_IRQ_EN) begin
          S_AXI_BRESP <= RESP_SLVERR;
        end
      end
    end
  end

  // AXI4-Lite read side
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= 1'b0;
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end else if (S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b1;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= RESP_OKAY;
        case (S_AXI_ARADDR)
          ADDR_CTRL: S_AXI_RDATA <= 32'h00000000;
          ADDR_STAT: S_AXI_RDATA <= {22'h000000, ofs_minus_q, ofs_plus_q, seek_end_q,
            err_q, oncyl_q, polarity_q, last_cyl_q, fine_q, state_q};
          ADDR_IRQ_ST: S_AXI_RDATA <= {29'h00000000, irq_st_q};
          ADDR_IRQ_CLR: S_AXI_RDATA <= 32'h00000000;
          ADDR_IRQ_EN: S_AXI_RDATA <= {29'h00000000, irq_en_q};
          default: begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Registered outputs
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      FINE_GATE_O <= 1'b0;
      COARSE_GATE_O <= 1'b1;
    end else begin
      FINE_GATE_O <= fine_q;
      COARSE_GATE_O <= !fine_q;
    end
  end
  assign LAST_CYL_O = last_cyl_q;
  assign FEEDBACK_POLARITY_O = polarity_q;
  assign ON_CYL_O = oncyl_q;
  assign SEEK_END_O = seek_end_q;
  assign SEEK_ERROR_O = err_q;
  assign OFFSET_PLUS_O = ofs_plus_q;
  assign OFFSET_MINUS_O = ofs_minus_q;
  assign RETURN_HOME_O = home_q;
  assign IRQ_O = irq_q;
endmodule // sfc_top

// file: bench/sfc_checker.sv
// Assertion checker for the sequencer top ports
`timescale 1ns/1ps
module sfc_checker
  import sfc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SEEK_START_I,
  input wire logic [8:0] DIFF_COUNT_I,
  input wire logic OFF_TRACK_I,
  input wire logic FINE_GATE_O,
  input wire logic COARSE_GATE_O,
  input wire logic LAST_CYL_O,
  input wire logic ON_CYL_O,
  input wire logic SEEK_END_O,
  input wire logic SEEK_ERROR_O,
  input wire logic OFFSET_PLUS_O,
  input wire logic OFFSET_MINUS_O
);
  logic [15:0] off_q;
  always_ff @(posedge CLK_I) begin
    off_q <= (RST_I || !OFF_TRACK_I) ? 16'h0000 : off_q + 16'h0001;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_gates_complement: assert property (FINE_GATE_O != COARSE_GATE_O)
    else $error("gates not complementary");
  a_seek_coarse: assert property (SEEK_START_I && !SEEK_ERROR_O |-> ##[1:3] COARSE_GATE_O)
    else $error("seek start kept fine path");
  a_last_cylinder: assert property (1'b1 |=> LAST_CYL_O == ($past(DIFF_COUNT_I) == 9'h001))
    else $error("last cylinder flag wrong");
  a_fine_cause: assert property ($rose(FINE_GATE_O) |-> $past(LAST_CYL_O) || $past(LAST_CYL_O, 2))
    else $error("fine set without last cylinder");
  a_oncyl_fine: assert property (ON_CYL_O |-> FINE_GATE_O)
    else $error("on cylinder without fine path");
  a_end_oncyl: assert property ($rose(ON_CYL_O) |=> SEEK_END_O)
    else $error("no seek end after on cylinder");
  a_end_error: assert property ($rose(SEEK_ERROR_O) |-> ##[0:1] SEEK_END_O)
    else $error("no seek end after error");
  a_offcyl_span: assert property ($fell(ON_CYL_O) |-> off_q >= OFFCYL_CYC && off_q <= OFFCYL_CYC + 8)
    else $error("off cylinder delay wrong");
  a_loss_error: assert property ($fell(ON_CYL_O) |-> ##[0:1] SEEK_ERROR_O)
    else $error("no error on loss");
  a_error_holds: assert property (SEEK_ERROR_O && SEEK_START_I |=> SEEK_ERROR_O)
    else $error("seek cleared error");
  a_offset_one: assert property (!(OFFSET_PLUS_O && OFFSET_MINUS_O))
    else $error("both offsets active");
  c_oncyl: cover property ($rose(ON_CYL_O));
  c_error: cover property ($rose(SEEK_ERROR_O));
  c_minus: cover property ($rose(OFFSET_MINUS_O));
endmodule // sfc_checker
bind sfc_top sfc_checker sfc_checker_inst (.CLK_I, .RST_I, .SEEK_START_I, .DIFF_COUNT_I,
  .OFF_TRACK_I, .FINE_GATE_O, .COARSE_GATE_O, .LAST_CYL_O, .ON_CYL_O, .SEEK_END_O,
  .SEEK_ERROR_O, .OFFSET_PLUS_O, .OFFSET_MINUS_O);

// file: bench/sfc_ctrl_model.sv
// Disk controller model issuing control tag commands
`timescale 1ns/1ps
module sfc_ctrl_model
  import sfc_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [9:0] cmd_i,
  output logic tag_strobe_o,
  output logic [1:0] tag_o,
  output logic [9:0] bus_o
);
  // Idle lines toggle so stale values never pass
  always @(posedge clk_i) begin
    tag_strobe_o <= go_i;
    tag_o <= go_i ? TAG_CTRL_SEL : ~tag_o;
    bus_o <= go_i ? cmd_i : ~bus_o;
  end
endmodule // sfc_ctrl_model

// file: bench/test_sfc_top.sv
// Self-checking bench for the servo fine control sequencer
`timescale 1ns/1ps
module test_sfc_top
  import sfc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, seek = 1'b0, odd = 1'b0, fine = 1'b0, sense = 1'b0;
  logic off = 1'b0, go = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [8:0] diff = 9'h000;
  logic [9:0] cmd = 10'h000, bus;
  logic [1:0] tag, bresp, rresp;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdata, rng = 32'h3893;
  logic strb, fg, cg, lc, pol, oc, se, er, op, om, rh, irq, awr, wr, bv, arr, rv;
  logic [6:0] ob;
  int bad_count = 0, check_count = 0, n;
  assign ob = {rh, irq, er, se, oc, cg, fg};
  initial begin
    forever #20 clk = ~clk;
  end
  sfc_ctrl_model sfc_ctrl_model_inst (.clk_i(clk), .go_i(go), .cmd_i(cmd),
    .tag_strobe_o(strb), .tag_o(tag), .bus_o(bus));
  sfc_top sfc_top_inst (.CLK_I(clk), .RST_I(rst), .SEEK_START_I(seek), .DEST_ODD_I(odd),
    .DIFF_COUNT_I(diff), .FINE_LVL_I(fine), .ONCYL_SENSE_I(sense), .OFF_TRACK_I(off),
    .TAG_STROBE_I(strb), .TAG_I(tag), .BUS_I(bus), .FINE_GATE_O(fg), .COARSE_GATE_O(cg),
    .LAST_CYL_O(lc), .FEEDBACK_POLARITY_O(pol), .ON_CYL_O(oc), .SEEK_END_O(se),
    .SEEK_ERROR_O(er), .OFFSET_PLUS_O(op), .OFFSET_MINUS_O(om), .RETURN_HOME_O(rh),
    .IRQ_O(irq), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wt(input int i, input logic v, input int lim);
    n = 0;
    while (ob[i] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      n++;
    end while (!bv && n < 50);
    bre <= 1'b0;
    chk(bv, 1'b1);
    chk(bresp, r);
  endtask
  task automatic axr(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      n++;
    end while (!rv && n < 50);
    rre <= 1'b0;
    chk(rv, 1'b1);
    chk(rdata & m, e);
    chk(rresp, r);
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    cyc(90000);
    bad_count++;
    conclude();
  end
  initial begin
    cyc(8);
    rst <= 1'b0;
    @(posedge clk);
    chk({ob, op, om, lc, pol}, 11'h020);
    axr(ADDR_IRQ_EN, 32'h7, 32'h0, RESP_OKAY);
    axr(32'h40, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    axw(32'h44, 32'h1, RESP_SLVERR);
    axw(ADDR_IRQ_EN, 32'h7, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      rng = xs(rng);
      @(posedge clk);
      cmd <= (rng[9:0] & 10'h3B3) | (i == 0 ? 10'h004 : i == 1 ? 10'h008 : 10'h00C);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      cyc(5);
      chk({op, om}, i == 1 ? 2'b01 : 2'b10);
    end
    rng = xs(rng);
    odd <= rng[0];
    seek <= 1'b1;
    sense <= 1'b1;
    fine <= 1'b1;
    @(posedge clk);
    seek <= 1'b0;
    repeat (6) begin
      rng = xs(rng);
      @(posedge clk);
      diff <= rng[8:0] | 9'h002;
    end
    cyc(4);
    chk({cg, oc, pol}, {2'b10, odd});
    fine <= 1'b0;
    cyc(3);
    diff <= 9'h001;
    cyc(5);
    chk(cg, 1'b1);
    fine <= 1'b1;
    wt(0, 1'b1, 20);
    chk(n < 20, 1'b1);
    wt(2, 1'b1, SETTLE_CYC + 20);
    chk(n >= SETTLE_CYC - 4 && n <= SETTLE_CYC + 8, 1'b1);
    cyc(2);
    chk({se, irq, fg}, 3'b111);
    axr(ADDR_IRQ_ST, 32'h7, 32'h3, RESP_OKAY);
    axw(ADDR_IRQ_CLR, 32'h7, RESP_OKAY);
    cyc(2);
    chk(irq, 1'b0);
    off <= 1'b1;
    cyc(100);
    off <= 1'b0;
    cyc(5);
    chk(oc, 1'b1);
    off <= 1'b1;
    wt(2, 1'b0, OFFCYL_CYC + 30);
    chk(n >= OFFCYL_CYC - 4 && n <= OFFCYL_CYC + 8, 1'b1);
    cyc(2);
    chk({er, se, irq}, 3'b111);
    off <= 1'b0;
    seek <= 1'b1;
    @(posedge clk);
    seek <= 1'b0;
    cyc(4);
    chk({er, se}, 2'b11);
    cmd <= 10'h040;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wt(6, 1'b1, 10);
    chk(n < 10, 1'b1);
    wt(4, 1'b0, 10);
    chk(n < 10, 1'b1);
    diff <= 9'h000;
    axw(ADDR_CTRL, 32'h1, RESP_OKAY);
    axr(ADDR_STAT, 32'hC7, 32'h1, RESP_OKAY);
    diff <= 9'h001;
    wt(0, 1'b1, 20);
    chk(n < 20, 1'b1);
    diff <= 9'h000;
    seek <= 1'b1;
    @(posedge clk);
    seek <= 1'b0;
    cyc(3);
    chk({cg, er}, 2'b10);
    conclude();
  end
endmodule // test_sfc_top
